//--- inc/pmr_cfg.svh
// Register offsets, field positions and reset values of the PHY register mirror
// Functional notes
// - Control bit 14 loops host data through PHY
// - Control bit 13 forces 100 or 10 Mbps
// - Control bit 12 enables auto-negotiation
// - Writing control bit 9 restarts auto-negotiation
// - Control bit 8 selects full or half duplex
// - Control bit 5 picks crossover algorithm variant
// - Control bit 4 forces crossed pair assignment
// - Control bit 3 disables automatic crossover
// - Control bit 1 disables port transmitter
// - Control bit 0 disables all port LEDs
// - Shared bits mirror per-port control register fields
// - Status bits 14:11 read one, 15 zero
// - Status bit 5 shows negotiation complete
// - Status bit 3 reads constant one
// - Status bit 2 follows link state
// - Status bits 0, 1, 6 read zero
// - Two read-only identifier words
// - Advertisement bit 10 offers pause capability
// - Advertisement bits 8:5 offer speed abilities
// - Partner bit 10 reports partner pause
// - Partner bits 8:5 report partner abilities
`ifndef PMR_CFG_SVH
`define PMR_CFG_SVH

`define PMR_OFS_CTRL      8'he4
`define PMR_OFS_STAT      8'he6
`define PMR_OFS_IDLO      8'he8
`define PMR_OFS_IDHI      8'hea
`define PMR_OFS_ADV       8'hec
`define PMR_OFS_LPA       8'hee
`define PMR_OFS_PCTRL     8'hf6

`define PMR_CB_LOOP       14
`define PMR_CB_SPD        13
`define PMR_CB_ANEN       12
`define PMR_CB_RST        9
`define PMR_CB_DPX        8
`define PMR_CB_XVAR       5
`define PMR_CB_FMDIX      4
`define PMR_CB_DMDIX      3
`define PMR_CB_TXDIS      1
`define PMR_CB_LEDOFF     0

`define PMR_PB_LEDOFF     15
`define PMR_PB_TXDIS      14
`define PMR_PB_RST        13
`define PMR_PB_DMDIX      10
`define PMR_PB_FMDIX      9
`define PMR_PB_ANEN       7
`define PMR_PB_SPD        6
`define PMR_PB_DPX        5
`define PMR_PB_PAUSE      4

`define PMR_STAT_FIXED    16'h7808
`define PMR_STAT_ANC      5
`define PMR_STAT_LINK     2
`define PMR_ADV_SEL       16'h0001
`define PMR_LPA_FIXED     16'h0001
`define PMR_ADV_RST       5'h1f
`define PMR_AB_PAUSE      10
`define PMR_AB_HI         8
`define PMR_AB_LO         5

`endif

//--- inc/pmr_pkg.sv
// Types shared by the PHY register mirror
package pmr_pkg;
    typedef struct packed {
        logic       loopback;
        logic       force_100;
        logic       an_enable;
        logic       force_full;
        logic       xover_variant;
        logic       force_mdix;
        logic       mdix_disable;
        logic       tx_disable;
        logic       led_disable;
    } pmr_ctrl_s;

    typedef struct packed {
        logic       pause;
        logic [3:0] abil;
    } pmr_abil_s;

    typedef enum logic [1:0] {
        PMR_AN_IDLE,
        PMR_AN_RUN,
        PMR_AN_DONE
    } pmr_an_e;
endpackage

//--- rtl/pmr_sync.sv
// Two-flop synchroniser for pin-level inputs
module pmr_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    // A zero-width bus has nothing to carry
    if (W < 1) begin : g_w_check
        $error("pmr_sync width must be at least one");
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_r <= '0;
            q_o    <= '0;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule

//--- rtl/pmr_top.sv
// PHY MII register mirror with per-port control sharing
`include "pmr_cfg.svh"
module pmr_top (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               sys_rst_i,
    // Register access
    input  wire logic               reg_wr_i,
    input  wire logic               reg_rd_i,
    input  wire logic [7:0]         reg_addr_i,
    input  wire logic [15:0]        reg_wdata_i,
    output logic      [15:0]        reg_rdata_o,
    // PHY state from the analog side
    input  wire logic               link_up_i,
    input  wire logic               an_done_i,
    input  wire logic               an_failed_i,
    input  wire logic               lp_pause_i,
    input  wire logic [3:0]         lp_abil_i,
    // Controls to the PHY
    output pmr_pkg::pmr_ctrl_s      ctrl_o,
    output pmr_pkg::pmr_abil_s      adv_o,
    output logic                    an_restart_o,
    output logic                    eff_100_o,
    output logic                    eff_full_o
);
    // Identifier values are arbitrary
    localparam logic [15:0] ID_LOW  = 16'h5a01;
    localparam logic [15:0] ID_HIGH = 16'h00a5;

    pmr_pkg::pmr_ctrl_s ctrl_r;
    pmr_pkg::pmr_abil_s adv_r;
    pmr_pkg::pmr_an_e   an_st_r;
    logic               rst_pulse_r;
    logic               link_s;
    logic               an_done_s;
    logic               an_failed_s;
    logic               lp_pause_s;
    logic [3:0]         lp_abil_s;
    logic               lp_pause_r;
    logic [3:0]         lp_abil_r;
    logic [15:0]        ctrl_rd;
    logic [15:0]        stat_rd;
    logic [15:0]        adv_rd;
    logic [15:0]        lpa_rd;
    logic [15:0]        pctrl_rd;
    logic [15:0]        rdata_nxt;
    logic               wr_ctrl;
    logic               wr_pctrl;
    logic               wr_adv;

    // Pin-level PHY status passes two flops first
    pmr_sync #(.W(8)) u_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       ({link_up_i, an_done_i, an_failed_i, lp_pause_i, lp_abil_i}),
        .q_o       ({link_s, an_done_s, an_failed_s, lp_pause_s, lp_abil_s})
    );

    assign wr_ctrl  = reg_wr_i && (reg_addr_i == `PMR_OFS_CTRL);
    assign wr_pctrl = reg_wr_i && (reg_addr_i == `PMR_OFS_PCTRL);
    assign wr_adv   = reg_wr_i && (reg_addr_i == `PMR_OFS_ADV);

    // One storage for bits visible in both control registers
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_r <= '{loopback: 1'b0, force_100: 1'b1, an_enable: 1'b1,
                        force_full: 1'b1, xover_variant: 1'b1, force_mdix: 1'b0,
                        mdix_disable: 1'b0, tx_disable: 1'b0, led_disable: 1'b0};
        end else if (wr_ctrl) begin
            ctrl_r.loopback      <= reg_wdata_i[`PMR_CB_LOOP];
            ctrl_r.force_100     <= reg_wdata_i[`PMR_CB_SPD];
            ctrl_r.an_enable     <= reg_wdata_i[`PMR_CB_ANEN];
            ctrl_r.force_full    <= reg_wdata_i[`PMR_CB_DPX];
            ctrl_r.xover_variant <= reg_wdata_i[`PMR_CB_XVAR];
            ctrl_r.force_mdix    <= reg_wdata_i[`PMR_CB_FMDIX];
            ctrl_r.mdix_disable  <= reg_wdata_i[`PMR_CB_DMDIX];
            ctrl_r.tx_disable    <= reg_wdata_i[`PMR_CB_TXDIS];
            ctrl_r.led_disable   <= reg_wdata_i[`PMR_CB_LEDOFF];
        end else if (wr_pctrl) begin
            ctrl_r.force_100    <= reg_wdata_i[`PMR_PB_SPD];
            ctrl_r.an_enable    <= reg_wdata_i[`PMR_PB_ANEN];
            ctrl_r.force_full   <= reg_wdata_i[`PMR_PB_DPX];
            ctrl_r.force_mdix   <= reg_wdata_i[`PMR_PB_FMDIX];
            ctrl_r.mdix_disable <= reg_wdata_i[`PMR_PB_DMDIX];
            ctrl_r.tx_disable   <= reg_wdata_i[`PMR_PB_TXDIS];
            ctrl_r.led_disable  <= reg_wdata_i[`PMR_PB_LEDOFF];
        end
    end

    // Advertisement, pause and abilities shared with port control
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            adv_r <= `PMR_ADV_RST;
        end else if (wr_adv) begin
            adv_r.pause <= reg_wdata_i[`PMR_AB_PAUSE];
            adv_r.abil  <= reg_wdata_i[`PMR_AB_HI:`PMR_AB_LO];
        end else if (wr_pctrl) begin
            adv_r.pause <= reg_wdata_i[`PMR_PB_PAUSE];
            adv_r.abil  <= reg_wdata_i[3:0];
        end
    end

    // Restart is a self-clearing pulse; control bit 9 always reads back 0
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rst_pulse_r <= 1'b0;
        end else begin
            rst_pulse_r <= (wr_ctrl && reg_wdata_i[`PMR_CB_RST])
                        || (wr_pctrl && reg_wdata_i[`PMR_PB_RST]);
        end
    end

    // Negotiation tracker; restart clears completion until PHY reports again
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            an_st_r <= pmr_pkg::PMR_AN_IDLE;
        end else begin
            case (an_st_r)
                pmr_pkg::PMR_AN_IDLE: begin
                    if (ctrl_r.an_enable)
                        an_st_r <= pmr_pkg::PMR_AN_RUN;
                end
                pmr_pkg::PMR_AN_RUN: begin
                    if (!ctrl_r.an_enable)
                        an_st_r <= pmr_pkg::PMR_AN_IDLE;
                    else if (an_done_s && !rst_pulse_r)
                        an_st_r <= pmr_pkg::PMR_AN_DONE;
                end
                pmr_pkg::PMR_AN_DONE: begin
                    if (!ctrl_r.an_enable)
                        an_st_r <= pmr_pkg::PMR_AN_IDLE;
                    else if (rst_pulse_r || !an_done_s)
                        an_st_r <= pmr_pkg::PMR_AN_RUN;
                end
                default: an_st_r <= pmr_pkg::PMR_AN_IDLE;
            endcase
        end
    end

    // Partner abilities captured only from completed negotiation
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lp_pause_r <= 1'b0;
            lp_abil_r  <= 4'h0;
        end else if (an_st_r == pmr_pkg::PMR_AN_IDLE) begin
            lp_pause_r <= 1'b0;
            lp_abil_r  <= 4'h0;
        end else if (an_done_s) begin
            lp_pause_r <= lp_pause_s;
            lp_abil_r  <= lp_abil_s;
        end
    end

    always_comb begin
        ctrl_rd = 16'h0000;
        ctrl_rd[`PMR_CB_LOOP]   = ctrl_r.loopback;
        ctrl_rd[`PMR_CB_SPD]    = ctrl_r.force_100;
        ctrl_rd[`PMR_CB_ANEN]   = ctrl_r.an_enable;
        ctrl_rd[`PMR_CB_DPX]    = ctrl_r.force_full;
        ctrl_rd[`PMR_CB_XVAR]   = ctrl_r.xover_variant;
        ctrl_rd[`PMR_CB_FMDIX]  = ctrl_r.force_mdix;
        ctrl_rd[`PMR_CB_DMDIX]  = ctrl_r.mdix_disable;
        ctrl_rd[`PMR_CB_TXDIS]  = ctrl_r.tx_disable;
        ctrl_rd[`PMR_CB_LEDOFF] = ctrl_r.led_disable;
        pctrl_rd = 16'h0000;
        pctrl_rd[`PMR_PB_LEDOFF] = ctrl_r.led_disable;
        pctrl_rd[`PMR_PB_TXDIS]  = ctrl_r.tx_disable;
        pctrl_rd[`PMR_PB_DMDIX]  = ctrl_r.mdix_disable;
        pctrl_rd[`PMR_PB_FMDIX]  = ctrl_r.force_mdix;
        pctrl_rd[`PMR_PB_ANEN]   = ctrl_r.an_enable;
        pctrl_rd[`PMR_PB_SPD]    = ctrl_r.force_100;
        pctrl_rd[`PMR_PB_DPX]    = ctrl_r.force_full;
        pctrl_rd[`PMR_PB_PAUSE]  = adv_r.pause;
        pctrl_rd[3:0]            = adv_r.abil;
        stat_rd = `PMR_STAT_FIXED;
        stat_rd[`PMR_STAT_ANC]  = (an_st_r == pmr_pkg::PMR_AN_DONE);
        stat_rd[`PMR_STAT_LINK] = link_s;
        adv_rd = `PMR_ADV_SEL;
        adv_rd[`PMR_AB_PAUSE]          = adv_r.pause;
        adv_rd[`PMR_AB_HI:`PMR_AB_LO] = adv_r.abil;
        lpa_rd = `PMR_LPA_FIXED;
        lpa_rd[`PMR_AB_PAUSE]          = lp_pause_r;
        lpa_rd[`PMR_AB_HI:`PMR_AB_LO] = lp_abil_r;
        case (reg_addr_i)
            `PMR_OFS_CTRL:  rdata_nxt = ctrl_rd;
            `PMR_OFS_STAT:  rdata_nxt = stat_rd;
            `PMR_OFS_IDLO:  rdata_nxt = ID_LOW;
            `PMR_OFS_IDHI:  rdata_nxt = ID_HIGH;
            `PMR_OFS_ADV:   rdata_nxt = adv_rd;
            `PMR_OFS_LPA:   rdata_nxt = lpa_rd;
            `PMR_OFS_PCTRL: rdata_nxt = pctrl_rd;
            default:        rdata_nxt = 16'h0000;
        endcase
    end

    // Read data registered one cycle after the read strobe
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            reg_rdata_o <= 16'h0000;
        else if (reg_rd_i)
            reg_rdata_o <= rdata_nxt;
    end

    // Effective mode: forced speed and duplex when negotiation is off, forced duplex only when it failed
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            eff_100_o  <= 1'b1;
            eff_full_o <= 1'b1;
        end else if (!ctrl_r.an_enable) begin
            eff_100_o  <= ctrl_r.force_100;
            eff_full_o <= ctrl_r.force_full;
        end else if (an_failed_s) begin
            eff_full_o <= ctrl_r.force_full;
        end
    end

    assign ctrl_o       = ctrl_r;
    assign adv_o        = adv_r;
    assign an_restart_o = rst_pulse_r;

    stat_fixed_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        reg_rd_i && reg_addr_i == `PMR_OFS_STAT |=> reg_rdata_o[15:11] == 5'h0f)
        else $error("status ability bits wrong");
    stat_link_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        reg_rd_i && reg_addr_i == `PMR_OFS_STAT |=> reg_rdata_o[2] == $past(link_s))
        else $error("link bit mismatch");
    ctrl_mirror_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_pctrl && !wr_ctrl |=> ctrl_r.an_enable == $past(reg_wdata_i[`PMR_PB_ANEN]))
        else $error("port control not mirrored");
    restart_pulse_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_ctrl && reg_wdata_i[`PMR_CB_RST] |=>
        an_restart_o ##1 (!an_restart_o || $past(wr_ctrl || wr_pctrl)))
        else $error("restart pulse wrong");
    forced_speed_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !ctrl_r.an_enable && $stable(ctrl_r) |=> eff_100_o == $past(ctrl_r.force_100))
        else $error("forced speed not applied");
    id_ro_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        reg_rd_i && reg_addr_i == `PMR_OFS_IDLO |=> reg_rdata_o == ID_LOW)
        else $error("id low wrong");
    lpa_idle_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        an_st_r == pmr_pkg::PMR_AN_IDLE |=> lp_abil_r == 4'h0)
        else $error("partner bits not cleared");
    loop_wr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_ctrl |=> ctrl_o.loopback == $past(reg_wdata_i[`PMR_CB_LOOP]))
        else $error("loopback not written");

    pctrl_restart_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_pctrl && reg_wdata_i[`PMR_PB_RST] |=> an_restart_o)
        else $error("port restart not pulsed");
    forced_duplex_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !ctrl_r.an_enable || an_failed_s |=> eff_full_o == $past(ctrl_r.force_full))
        else $error("forced duplex not applied");
    an_speed_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ctrl_r.an_enable |=> $stable(eff_100_o))
        else $error("forced speed leaked into negotiation");
    an_off_idle_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !ctrl_r.an_enable |=> an_st_r == pmr_pkg::PMR_AN_IDLE)
        else $error("negotiation runs while disabled");
    anc_restart_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rst_pulse_r |=> an_st_r != pmr_pkg::PMR_AN_DONE)
        else $error("completion kept across restart");

    stat_ancap_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        reg_rd_i && reg_addr_i == `PMR_OFS_STAT |=> reg_rdata_o[3] == 1'b1)
        else $error("negotiation ability bit wrong");
    stat_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        reg_rd_i && reg_addr_i == `PMR_OFS_STAT |=> (reg_rdata_o & 16'h07d3) == 16'h0000)
        else $error("unsupported status bits set");
    id_high_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        reg_rd_i && reg_addr_i == `PMR_OFS_IDHI |=> reg_rdata_o == ID_HIGH)
        else $error("id high wrong");
    ctrl_pad_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        reg_rd_i && reg_addr_i == `PMR_OFS_CTRL |=> (reg_rdata_o & 16'h8ec4) == 16'h0000)
        else $error("control reserved bits set");
    unmapped_rd_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        reg_rd_i && reg_addr_i == 8'hf0 |=> reg_rdata_o == 16'h0000)
        else $error("unmapped read not zero");

    xover_wr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_ctrl |=> ctrl_o.xover_variant == $past(reg_wdata_i[`PMR_CB_XVAR]))
        else $error("crossover variant not written");
    mdix_force_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_ctrl |=> ctrl_o.force_mdix == $past(reg_wdata_i[`PMR_CB_FMDIX]))
        else $error("forced crossing not written");
    mdix_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_ctrl |=> ctrl_o.mdix_disable == $past(reg_wdata_i[`PMR_CB_DMDIX]))
        else $error("crossover disable not written");
    txdis_wr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_ctrl |=> ctrl_o.tx_disable == $past(reg_wdata_i[`PMR_CB_TXDIS]))
        else $error("transmit disable not written");
    led_wr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_ctrl |=> ctrl_o.led_disable == $past(reg_wdata_i[`PMR_CB_LEDOFF]))
        else $error("led disable not written");

    pause_wr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_adv |=> adv_o.pause == $past(reg_wdata_i[`PMR_AB_PAUSE]))
        else $error("pause advertisement not written");
    adv_wr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_adv |=> adv_o.abil == $past(reg_wdata_i[`PMR_AB_HI:`PMR_AB_LO]))
        else $error("ability advertisement not written");
    lpa_capture_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        an_st_r != pmr_pkg::PMR_AN_IDLE && an_done_s |=> lp_pause_r == $past(lp_pause_s))
        else $error("partner pause not captured");
    lpa_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        an_st_r != pmr_pkg::PMR_AN_IDLE && !an_done_s |=> $stable(lp_abil_r))
        else $error("partner bits changed without completion");
endmodule

//--- testbench/pmr_tb.sv
// Self-checking bench for the PHY register mirror
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // Identifier words chosen by the design, values arbitrary
    localparam logic [15:0] ID_LO = 16'h5a01;
    localparam logic [15:0] ID_HI = 16'h00a5;
    logic                clk_i;
    logic                sys_rst_i;
    logic                reg_wr_i;
    logic                reg_rd_i;
    logic [7:0]          reg_addr_i;
    logic [15:0]         reg_wdata_i;
    logic [15:0]         reg_rdata_o;
    logic                link_up_i;
    logic                an_done_i;
    logic                an_failed_i;
    logic                lp_pause_i;
    logic [3:0]          lp_abil_i;
    pmr_pkg::pmr_ctrl_s  ctrl_o;
    pmr_pkg::pmr_abil_s  adv_o;
    logic                an_restart_o;
    logic                eff_100_o;
    logic                eff_full_o;
    int                  n_mismatch = 0;
    int                  num_checks = 0;
    // Control bit and its per-port position, -1 where not shared
    int                  cb [9] = '{14, 13, 12, 8, 5, 4, 3, 1, 0};
    int                  pb [9] = '{-1, 6, 7, 5, -1, 9, 10, 14, 15};
    logic [7:0]          ro_a [5] = '{8'he6, 8'he8, 8'hea, 8'hee, 8'hf0};
    logic [15:0]         ro_e [5] = '{16'h7808, ID_LO, ID_HI, 16'h0001, 16'h0000};
    logic [15:0]         pexp;

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    pmr_top DUT (
        .clk_i        (clk_i),
        .sys_rst_i    (sys_rst_i),
        .reg_wr_i     (reg_wr_i),
        .reg_rd_i     (reg_rd_i),
        .reg_addr_i   (reg_addr_i),
        .reg_wdata_i  (reg_wdata_i),
        .reg_rdata_o  (reg_rdata_o),
        .link_up_i    (link_up_i),
        .an_done_i    (an_done_i),
        .an_failed_i  (an_failed_i),
        .lp_pause_i   (lp_pause_i),
        .lp_abil_i    (lp_abil_i),
        .ctrl_o       (ctrl_o),
        .adv_o        (adv_o),
        .an_restart_o (an_restart_o),
        .eff_100_o    (eff_100_o),
        .eff_full_o   (eff_full_o)
    );

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        #1;
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(posedge clk_i);
        #1;
        reg_wr_i = 1'b0;
    endtask

    // Read data is registered, so it is taken just after the strobe edge
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        #1;
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(posedge clk_i);
        #1;
        reg_rd_i = 1'b0;
        chk(name, exp, reg_rdata_o);
    endtask

    task automatic results();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        sys_rst_i = 1'b1;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 16'h0000;
        link_up_i = 1'b0;
        an_done_i = 1'b0;
        an_failed_i = 1'b0;
        lp_pause_i = 1'b0;
        lp_abil_i = 4'h0;
        repeat (20) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        chk("ctrl_o", 16'h00f0, {7'h00, ctrl_o});
        chk("adv_o", 16'h001f, {11'h000, adv_o});
        chk("eff", 16'h0003, {14'h0000, eff_100_o, eff_full_o});
        rd_chk("ctrl", 8'he4, 16'h3120);
        rd_chk("stat", 8'he6, 16'h7808);
        rd_chk("adv", 8'hec, 16'h05e1);
        rd_chk("pctrl", 8'hf6, 16'h00ff);
        // Fixed words must shrug off writes of all ones
        for (int i = 0; i < 5; i++) begin
            wr(ro_a[i], 16'hffff);
            rd_chk("ro", ro_a[i], ro_e[i]);
        end
        // One control bit at a time, shared ones seen in both registers
        for (int i = 0; i < 9; i++) begin
            wr(8'he4, 16'h0001 << cb[i]);
            rd_chk("ctrl", 8'he4, 16'h0001 << cb[i]);
            chk("ctrl_o", 16'h0001 << (8 - i), {7'h00, ctrl_o});
            pexp = (pb[i] < 0) ? 16'h001f : (16'h001f | (16'h0001 << pb[i]));
            rd_chk("pctrl", 8'hf6, pexp);
            // Effective mode follows forced speed and duplex while negotiation is off
            if (cb[i] != 12) begin
                chk("eff", {14'h0, cb[i] == 13, cb[i] == 8}, {14'h0, eff_100_o, eff_full_o});
            end
        end
        wr(8'he4, 16'h0000);
        wr(8'hf6, 16'hc000);
        rd_chk("ctrl", 8'he4, 16'h0003);
        chk("ctrl_o", 16'h0003, {7'h00, ctrl_o});
        rd_chk("adv", 8'hec, 16'h0001);
        wr(8'hec, 16'hfdff);
        rd_chk("adv", 8'hec, 16'h05e1);
        chk("adv_o", 16'h001f, {11'h000, adv_o});
        rd_chk("pctrl", 8'hf6, 16'hc01f);
        wr(8'hec, 16'h0120);
        chk("adv_o", 16'h0009, {11'h000, adv_o});
        wr(8'hf6, 16'h00ff);
        wr(8'he4, 16'h3300);
        chk("restart", 16'h0001, {15'h0000, an_restart_o});
        @(posedge clk_i);
        #1;
        chk("restart", 16'h0000, {15'h0000, an_restart_o});
        rd_chk("ctrl", 8'he4, 16'h3100);
        wr(8'hf6, 16'h20ff);
        chk("restart", 16'h0001, {15'h0000, an_restart_o});
        // Synchroniser and negotiation state need a few cycles
        link_up_i = 1'b1;
        an_done_i = 1'b1;
        lp_pause_i = 1'b1;
        lp_abil_i = 4'ha;
        repeat (6) @(posedge clk_i);
        #1;
        rd_chk("stat", 8'he6, 16'h782c);
        rd_chk("lpa", 8'hee, 16'h0541);
        wr(8'hee, 16'h0000);
        rd_chk("lpa", 8'hee, 16'h0541);
        link_up_i = 1'b0;
        repeat (6) @(posedge clk_i);
        #1;
        rd_chk("stat", 8'he6, 16'h7828);
        // Failed negotiation keeps forced duplex but holds speed
        an_failed_i = 1'b1;
        an_done_i = 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
        chk("eff", 16'h0001, {14'h0000, eff_100_o, eff_full_o});
        rd_chk("stat", 8'he6, 16'h7808);
        rd_chk("lpa", 8'hee, 16'h0541);
        results();
    end
endmodule
